/* File: hw/hid_defs.vh */
// Register map, field positions and reset values of the interrupt descriptor decoder
`ifndef HID_DEFS_VH
`define HID_DEFS_VH
`define HID_ADDR_W         8
`define HID_OFF_DESC_LO    8'h00
`define HID_OFF_DESC_HI    8'h04
`define HID_OFF_SCHED      8'h08
`define HID_OFF_STATUS     8'h0c
`define HID_OFF_IRQ_STAT   8'h10
`define HID_OFF_IRQ_MASK   8'h14
`define HID_LO_VALID       0
`define HID_LO_BYTES_LSB   3
`define HID_LO_BYTES_MSB   17
`define HID_LO_MAXP_LSB    18
`define HID_LO_MAXP_MSB    28
`define HID_LO_MULT_LSB    29
`define HID_LO_MULT_MSB    30
`define HID_LO_EP0         31
`define HID_LO_WMASK       32'hffff_fff9
`define HID_HI_EPH_LSB     0
`define HID_HI_EPH_MSB     2
`define HID_HI_ADDR_LSB    3
`define HID_HI_ADDR_MSB    9
`define HID_HI_TOKEN_LSB   10
`define HID_HI_TOKEN_MSB   11
`define HID_HI_KIND_LSB    12
`define HID_HI_KIND_MSB    13
`define HID_HI_SPLIT       14
`define HID_HI_WMASK       32'h0000_7fff
`define HID_SC_FRAME_LSB   0
`define HID_SC_FRAME_MSB   7
`define HID_SC_MASK_LSB    8
`define HID_SC_MASK_MSB    15
`define HID_SC_IVL_LSB     16
`define HID_SC_IVL_MSB     19
`define HID_SC_WMASK       32'h000f_ffff
`define HID_KIND_INTR      2'h3
`define HID_TOKEN_OUT      2'h0
`define HID_TOKEN_IN       2'h1
`define HID_IVL_MS_FIRST   4'h5
`define HID_IVL_MAX        4'h9
`define HID_IRQ_DONE       0
`define HID_IRQ_FATAL      1
`define HID_IRQ_CFG        2
`define HID_IRQ_W          3
`define HID_RST_32         32'h0000_0000
`define HID_RST_HI         15'h0000
`define HID_RST_SC         20'h00000
`define HID_RST_REM        15'h0000
`define HID_RST_MULT       2'h0
`endif

/* File: hw/hid_desc_decode.v */
// Periodic high-speed interrupt descriptor decoder and packet sequencer
//
// Operation
// [R1] Interval codes 1 to 4 need frame field bits 7:3 at zero and poll only by the activity mask.
// [R2] Interval codes 5 to 9 match 1 to 5 low frame phase bits, and the mask picks the microframe.
// [R3] Descriptor bit 46 selects a direct high-speed transaction at 0 and a split transaction at 1.
// [R4] Endpoint kind 11b marks an interrupt endpoint, the only kind this decoder executes.
// [R5] Token field 00 issues an OUT token and 01 an IN token.
// [R6] Each packet goes to the function named by the 7-bit function address.
// [R7] The 4-bit endpoint number joins the three low bits of the upper word and bit 31 of the lower word.
// [R8] At most as many packets as the 2-bit multiplier says are issued per execution.
// [R9] Software programs the multiplier as 01b, 10b or 11b and never 00b.
// [R10] No single packet exceeds the 11-bit maximum payload size.
// [R11] The total transfer comes from the 15-bit byte count, covering up to 32 kbytes.
// [R12] The valid bit is cleared when the descriptor completes or at once on a fatal error.
// [R13] Software sets the valid bit to 1 when it has payload, keeping the descriptor live across frames.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "hid_defs.vh"

module hid_desc_decode (
  input  wire        clk_sys,          // 125 MHz core clock
  input  wire        rstn,             // Asynchronous reset
  input  wire [7:0]  reg_addr,         // Register byte address
  input  wire [31:0] reg_wdata,        // Write data
  input  wire        reg_wr,           // Write strobe
  input  wire        reg_rd,           // Read strobe
  output reg  [31:0] reg_rdata,        // Read data, cycle after the strobe
  input  wire        uframe_start,     // Pulse at each microframe start
  input  wire [4:0]  frame_num,        // Low bits of current frame number
  input  wire [2:0]  uframe_num,       // Microframe within the frame
  input  wire        pkt_done,         // Packet finished on the bus
  input  wire [10:0] pkt_bytes,        // Bytes moved by that packet
  input  wire        fatal_err,        // Fatal error from the bus engine
  output reg         pkt_start,        // One-cycle packet request
  output reg         pkt_is_in,        // Token is IN when high
  output reg         pkt_split,        // Split transaction when high
  output reg  [6:0]  pkt_function,     // Target function address
  output reg  [3:0]  pkt_endpoint,     // Target endpoint number
  output reg  [10:0] pkt_len,          // Bytes requested this packet
  output reg         irq               // Level interrupt
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ISSUE = 2'h1;
  localparam [1:0] ST_WAIT  = 2'h2;

  reg  [31:0]          lo_q;
  reg  [14:0]          hi_q;
  reg  [19:0]          sc_q;
  reg  [1:0]           state_q;
  reg  [1:0]           state_d;
  reg  [14:0]          rem_q;
  reg  [14:0]          rem_d;
  reg  [1:0]           mult_left_q;
  reg  [1:0]           mult_left_d;
  reg  [`HID_IRQ_W-1:0] irq_stat_q;
  reg  [`HID_IRQ_W-1:0] irq_mask_q;
  reg  [`HID_IRQ_W-1:0] ev;
  reg                  hw_clear_valid;
  reg                  issue;
  reg  [10:0]          len_d;
  wire [`HID_IRQ_W-1:0] stat_d;

  wire [10:0] max_size  = lo_q[`HID_LO_MAXP_MSB:`HID_LO_MAXP_LSB];
  wire [1:0]  mult      = lo_q[`HID_LO_MULT_MSB:`HID_LO_MULT_LSB];
  wire        valid     = lo_q[`HID_LO_VALID];
  wire [1:0]  token     = hi_q[`HID_HI_TOKEN_MSB:`HID_HI_TOKEN_LSB];
  wire [1:0]  kind      = hi_q[`HID_HI_KIND_MSB:`HID_HI_KIND_LSB];
  wire [7:0]  frame_fld = sc_q[`HID_SC_FRAME_MSB:`HID_SC_FRAME_LSB];
  wire [7:0]  act_mask  = sc_q[`HID_SC_MASK_MSB:`HID_SC_MASK_LSB];
  wire [3:0]  ivl       = sc_q[`HID_SC_IVL_MSB:`HID_SC_IVL_LSB];

  // Exact byte-address match shared by all register write decodes
  function reg_sel;
    input [7:0] addr;
    input [7:0] offset;
    begin
      reg_sel = (addr == offset);
    end
  endfunction

  wire wr_lo = reg_wr && reg_sel(reg_addr, `HID_OFF_DESC_LO);
  wire wr_hi = reg_wr && reg_sel(reg_addr, `HID_OFF_DESC_HI);
  wire wr_sc = reg_wr && reg_sel(reg_addr, `HID_OFF_SCHED);
  wire wr_is = reg_wr && reg_sel(reg_addr, `HID_OFF_IRQ_STAT);
  wire wr_im = reg_wr && reg_sel(reg_addr, `HID_OFF_IRQ_MASK);

  // Phase mask of frame-field bits 7:3 for an interval code
  function [4:0] phase_bits;
    input [3:0] code;
    begin
      case (code)
        4'h5:    phase_bits = 5'h01;
        4'h6:    phase_bits = 5'h03;
        4'h7:    phase_bits = 5'h07;
        4'h8:    phase_bits = 5'h0f;
        4'h9:    phase_bits = 5'h1f;
        default: phase_bits = 5'h00;
      endcase
    end
  endfunction

  // Schedule match for the current microframe
  function sched_hit;
    input [3:0] code;
    input [7:0] ffld;
    input [7:0] amask;
    input [4:0] fnum;
    input [2:0] ufn;
    begin
      if (code < `HID_IVL_MS_FIRST) begin
        // [R1] mask-only polling
        sched_hit = (ffld[7:3] == 5'h00) && amask[ufn];
      end else begin
        // [R2] frame phase match
        sched_hit = ((ffld[7:3] & phase_bits(code)) == (fnum & phase_bits(code))) && amask[ufn];
      end
    end
  endfunction

  // Configurations that this decoder refuses to run
  // [R4] interrupt endpoints only
  wire kind_bad  = (kind != `HID_KIND_INTR);
  // [R5] only OUT and IN
  wire token_bad = (token != `HID_TOKEN_OUT) && (token != `HID_TOKEN_IN);
  // A 00b multiplier has no defined behaviour, so it is refused rather than guessed at
  wire mult_bad  = (mult == 2'h0);
  // Interval codes outside 1 to 9 have no polling rate
  wire ivl_bad   = (ivl == 4'h0) || (ivl > `HID_IVL_MAX);
  wire cfg_bad   = kind_bad || token_bad || mult_bad || ivl_bad;

  wire hit = valid && sched_hit(ivl, frame_fld, act_mask, frame_num, uframe_num);

  // [R10] remaining bytes, never above the maximum payload size
  function [10:0] clip_len;
    input [14:0] left;
    input [10:0] limit;
    begin
      if (left > {4'h0, limit}) begin
        clip_len = limit;
      end else begin
        clip_len = left[10:0];
      end
    end
  endfunction

  // Bytes the finished packet moved, widened to the counter width
  wire [14:0] moved     = {4'h0, pkt_bytes};
  wire        count_out = (moved >= rem_q);
  // A packet shorter than asked for ends the transfer early
  wire        pkt_short = (pkt_bytes < pkt_len);

  always @* begin
    state_d        = state_q;
    rem_d          = rem_q;
    mult_left_d    = mult_left_q;
    ev             = {`HID_IRQ_W{1'b0}};
    hw_clear_valid = 1'b0;
    issue          = 1'b0;
    // [R10] clip packet to the maximum payload size
    len_d          = clip_len(rem_q, max_size);
    case (state_q)
      // A microframe start is only seen here; one that falls mid-packet is dropped
      ST_IDLE: begin
        if (uframe_start && hit) begin
          if (cfg_bad) begin
            ev[`HID_IRQ_CFG] = 1'b1;
            hw_clear_valid   = 1'b1;
          end else begin
            // [R8] packet budget per execution
            mult_left_d = mult;
            state_d     = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        issue   = 1'b1;
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (pkt_done) begin
          rem_d = count_out ? `HID_RST_REM : (rem_q - moved);
          // A short packet ends the transfer as well as an exhausted count
          if (count_out || pkt_short) begin
            // [R12] whole descriptor executed
            ev[`HID_IRQ_DONE] = 1'b1;
            hw_clear_valid    = 1'b1;
            state_d           = ST_IDLE;
          end else if (mult_left_q > 2'h1) begin
            mult_left_d = mult_left_q - 2'h1;
            state_d     = ST_ISSUE;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (fatal_err && valid) begin
      // [R12] fatal error ends it at once
      ev[`HID_IRQ_FATAL] = 1'b1;
      hw_clear_valid     = 1'b1;
      state_d            = ST_IDLE;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lo_q <= `HID_RST_32;
    end else if (wr_lo) begin
      // [R13] software arms the descriptor; its write wins over a clear
      lo_q <= reg_wdata & `HID_LO_WMASK;
    end else if (hw_clear_valid) begin
      lo_q[`HID_LO_VALID] <= 1'b0;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hi_q <= `HID_RST_HI;
    end else if (wr_hi) begin
      hi_q <= reg_wdata[`HID_HI_SPLIT:0];
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sc_q <= `HID_RST_SC;
    end else if (wr_sc) begin
      sc_q <= reg_wdata[`HID_SC_IVL_MSB:0];
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mult_left_q <= `HID_RST_MULT;
    end else begin
      mult_left_q <= mult_left_d;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rem_q <= `HID_RST_REM;
    end else if (wr_lo) begin
      // [R11] total size reloads with each new descriptor
      rem_q <= reg_wdata[`HID_LO_BYTES_MSB:`HID_LO_BYTES_LSB];
    end else begin
      rem_q <= rem_d;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pkt_start <= 1'b0;
    end else begin
      pkt_start <= issue;
    end
  end

  // Fields are captured with the request and held until the next one
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pkt_is_in    <= 1'b0;
      pkt_split    <= 1'b0;
      pkt_function <= 7'h00;
      pkt_endpoint <= 4'h0;
      pkt_len      <= 11'h000;
    end else begin
      if (issue) begin
        // [R5] token direction
        pkt_is_in    <= (token == `HID_TOKEN_IN);
        // [R3] split or direct execution
        pkt_split    <= hi_q[`HID_HI_SPLIT];
        // [R6] function address
        pkt_function <= hi_q[`HID_HI_ADDR_MSB:`HID_HI_ADDR_LSB];
        // [R7] endpoint number assembly
        pkt_endpoint <= {hi_q[`HID_HI_EPH_MSB:`HID_HI_EPH_LSB], lo_q[`HID_LO_EP0]};
        pkt_len      <= len_d;
      end
    end
  end

  // Sticky events: a new event beats a simultaneous write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < `HID_IRQ_W; gi = gi + 1) begin : g_stat
      assign stat_d[gi] = ev[gi] | (irq_stat_q[gi] & ~(wr_is & reg_wdata[gi]));
    end
  endgenerate

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= {`HID_IRQ_W{1'b0}};
    end else begin
      irq_stat_q <= stat_d;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_mask_q <= {`HID_IRQ_W{1'b0}};
    end else if (wr_im) begin
      irq_mask_q <= reg_wdata[`HID_IRQ_W-1:0];
    end
  end

  // Registered so the pin cannot glitch; it trails the status bits by one cycle
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Live sequencer state for software, read-only
  wire [31:0] status_word = {13'h0000, mult_left_q, state_q, rem_q};

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= `HID_RST_32;
    end else if (reg_rd) begin
      case (reg_addr)
        `HID_OFF_DESC_LO:  reg_rdata <= lo_q;
        `HID_OFF_DESC_HI:  reg_rdata <= {17'h00000, hi_q};
        `HID_OFF_SCHED:    reg_rdata <= {12'h000, sc_q};
        `HID_OFF_STATUS:   reg_rdata <= status_word;
        `HID_OFF_IRQ_STAT: reg_rdata <= {29'h00000000, irq_stat_q};
        `HID_OFF_IRQ_MASK: reg_rdata <= {29'h00000000, irq_mask_q};
        default:           reg_rdata <= `HID_RST_32;
      endcase
    end else begin
      reg_rdata <= `HID_RST_32;
    end
  end

endmodule // hid_desc_decode

/* File: tb/hid_desc_decode_props.sv */
// Port assertions for the descriptor decoder
`timescale 1ns/1ps
module hid_props (
  input wire        clk_sys,      // Clock
  input wire        rstn,         // Reset
  input wire [7:0]  reg_addr,     // Address
  input wire [31:0] reg_wdata,    // Write data
  input wire        reg_wr,       // Write
  input wire        uframe_start, // Microframe
  input wire        pkt_done,     // Done
  input wire        pkt_start,    // Request
  input wire        pkt_is_in,    // IN token
  input wire        pkt_split,    // Split
  input wire [6:0]  pkt_function, // Function
  input wire [3:0]  pkt_endpoint, // Endpoint
  input wire [10:0] pkt_len       // Length
);
  reg [31:0] lo_q, hi_q;
  reg [1:0]  cnt_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Shadow of the descriptor words as software wrote them
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lo_q <= 32'h0;
      hi_q <= 32'h0;
      cnt_q <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h00) lo_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'h04) hi_q <= reg_wdata;
      cnt_q <= uframe_start ? 2'h0 : cnt_q + {1'b0, pkt_start};
    end
  end
  a_start_pulse: assert property (pkt_start |=> !pkt_start) else $error("long pkt_start");
  a_start_cause: assert property (pkt_start |-> $past(uframe_start, 2) || $past(pkt_done, 2))
    else $error("pkt_start without cause");
  a_token_dir: assert property (pkt_start |-> pkt_is_in == hi_q[10]) else $error("bad token");
  a_split_sel: assert property (pkt_start |-> pkt_split == hi_q[14]) else $error("bad split");
  a_function_addr: assert property (pkt_start |-> pkt_function == hi_q[9:3]) else $error("bad function");
  a_endpoint_join: assert property (pkt_start |-> pkt_endpoint == {hi_q[2:0], lo_q[31]})
    else $error("bad endpoint");
  a_len_bound: assert property (pkt_start |-> pkt_len <= lo_q[28:18] && pkt_len <= lo_q[17:3])
    else $error("packet too long");
  a_packet_budget: assert property (pkt_start |-> cnt_q < lo_q[30:29]) else $error("too many packets");
endmodule // hid_props
bind hid_desc_decode hid_props u_props (.*);

/* File: tb/hid_usb_fn.sv */
// Far-side function model answering packet requests
`timescale 1ns/1ps
module hid_usb_fn (
  input  wire        clk_sys,   // Clock
  input  wire        rstn,      // Reset
  input  wire        pkt_start, // Request
  input  wire [10:0] pkt_len,   // Bytes asked
  input  wire [1:0]  dly,       // Extra latency
  input  wire        short_pkt, // Answer one byte short
  output reg         pkt_done,  // Done pulse
  output reg  [10:0] pkt_bytes  // Bytes moved
);
  integer wait_q;
  // Byte count toggles outside the done pulse so stale values never match
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_q <= -1;
      pkt_done <= 1'b0;
      pkt_bytes <= 11'h7ff;
    end else begin
      pkt_done <= 1'b0;
      pkt_bytes <= ~pkt_bytes;
      if (pkt_start) wait_q <= dly;
      else if (wait_q > 0) wait_q <= wait_q - 1;
      else if (wait_q == 0) begin
        wait_q <= -1;
        pkt_done <= 1'b1;
        pkt_bytes <= (short_pkt && pkt_len != 11'h000) ? pkt_len - 11'h001 : pkt_len;
      end
    end
  end
endmodule // hid_usb_fn

/* File: tb/hid_desc_decode_test.sv */
// Self-checking bench for the descriptor decoder
`timescale 1ns/1ps
module hid_desc_decode_test;
  reg clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0, uframe_start = 0, fatal_err = 0;
  reg [7:0] reg_addr = 0;
  reg [31:0] reg_wdata = 0, lo, hi;
  reg [4:0] frame_num = 0;
  reg [2:0] uframe_num = 0;
  reg [1:0] dly = 0;
  reg short_pkt = 0;
  reg [15:0] rnd = 16'h003c;
  wire [31:0] reg_rdata;
  wire pkt_done, pkt_start, pkt_is_in, pkt_split, irq;
  wire [10:0] pkt_bytes, pkt_len;
  wire [6:0] pkt_function;
  wire [3:0] pkt_endpoint;
  integer err_count = 0, tests_run = 0, rem, mx, mult, n, go, i;
  hid_desc_decode i_dut (.*);
  hid_usb_fn i_fn (.*);
  initial forever #4 clk_sys = ~clk_sys;
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function integer npk(input integer r, input integer m, input integer k);
    begin
      npk = 1;
      while (npk < k && r > m) begin
        npk = npk + 1;
        r = r - m;
      end
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] exp, input [47:0] what);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("unexpected %0s exp %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk_sys) reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk_sys) reg_rd <= 1'b0;
      #1 chk(reg_rdata, e, "rdata");
    end
  endtask
  task load(input [1:0] tok, input [1:0] kind, input [3:0] ivl, input [7:0] ff, input [7:0] am);
    begin
      rnd = lfsr(rnd);
      mult = rnd[1:0] == 2'h0 ? 1 : rnd[1:0];
      mx = 4 + rnd[5:2];
      rem = rnd[11:6];
      hi = {17'h0, rnd[12], kind, tok, rnd[15:9], rnd[2:0]};
      // valid set last, once all fields stand
      lo = {rnd[13], mult[1:0], mx[10:0], rem[14:0], 3'h1};
      wr(8'h04, hi);
      wr(8'h08, {12'h0, ivl, am, ff});
      wr(8'h00, lo);
    end
  endtask
  task sof(input [4:0] fn, input [2:0] un, input integer expn);
    begin
      @(posedge clk_sys) {uframe_start, frame_num, uframe_num} <= {1'b1, fn, un};
      @(posedge clk_sys) uframe_start <= 1'b0;
      n = 0;
      repeat (40) begin
        @(posedge clk_sys) #1;
        if (pkt_start === 1'b1) begin
          n = n + 1;
          chk(pkt_len, rem < mx ? rem : mx, "len");
          chk({pkt_is_in, pkt_split, pkt_function, pkt_endpoint}, {hi[10], hi[14], hi[9:3], hi[2:0], lo[31]}, "fields");
          rem = rem < mx ? 0 : rem - mx;
        end
      end
      chk(n, expn, "npkt");
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #400000 err_count = err_count + 1;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h00, 0);
    rd(8'h18, 0);
    wr(8'h14, 32'h7);
    for (i = 0; i < 8; i = i + 1) begin
      dly <= i[1:0];
      load({1'b0, i[0]}, 2'h3, 4'h1 + i[1:0], 8'h0, 8'hff);
      chk(irq, 1'b0, "irq");
      go = 1;
      while (go) begin
        sof(5'h0, i[2:0], npk(rem, mx, mult));
        go = rem > 0;
      end
      rd(8'h00, lo ^ 32'h1);
      rd(8'h10, 32'h1);
      chk(irq, 1'b1, "irq");
      wr(8'h10, 32'h7);
      $display("transfer %0d done", i);
    end
    load(2'h0, 2'h3, 4'h2, 8'h08, 8'hff);
    sof(5'h0, 3'h0, 0);
    wr(8'h14, 32'h0);
    load(2'h1, 2'h3, 4'h6, 8'h10, 8'h10);
    sof(5'h1, 3'h4, 0);
    sof(5'h6, 3'h3, 0);
    sof(5'h6, 3'h4, npk(rem, mx, mult));
    chk(irq, 1'b0, "irq");
    wr(8'h10, 32'h7);
    load(2'h0, 2'h2, 4'h1, 8'h0, 8'hff);
    sof(5'h0, 3'h0, 0);
    rd(8'h10, 32'h4);
    rd(8'h00, lo ^ 32'h1);
    wr(8'h10, 32'h7);
    load(2'h2, 2'h3, 4'h1, 8'h0, 8'hff);
    sof(5'h0, 3'h0, 0);
    rd(8'h10, 32'h4);
    wr(8'h10, 32'h7);
    load(2'h0, 2'h3, 4'h9, 8'hf8, 8'h01);
    sof(5'h0f, 3'h0, 0);
    sof(5'h1f, 3'h0, npk(rem, mx, mult));
    wr(8'h10, 32'h7);
    short_pkt <= 1'b1;
    load(2'h1, 2'h3, 4'h4, 8'h0, 8'h01);
    sof(5'h0, 3'h0, 1);
    short_pkt <= 1'b0;
    rd(8'h10, 32'h1);
    rd(8'h00, lo ^ 32'h1);
    wr(8'h10, 32'h7);
    $display("phase, token and short packet tests done");
    dly <= 2'h3;
    load(2'h1, 2'h3, 4'h1, 8'h0, 8'hff);
    @(posedge clk_sys) uframe_start <= 1'b1;
    @(posedge clk_sys) uframe_start <= 1'b0;
    @(posedge clk_sys) fatal_err <= 1'b1;
    @(posedge clk_sys) fatal_err <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(8'h10, 32'h2);
    rd(8'h00, lo ^ 32'h1);
    $display("schedule, refusal and fatal tests done");
    stop_test;
  end
endmodule // hid_desc_decode_test
